// [common/eep_pkg.sv]
// Shared constants for the two-wire serial memory link
package eep_pkg;
    localparam int EEP_ADDR_W = 11;
    localparam int EEP_DATA_W = 8;
    localparam int EEP_PAGE_W = 4;
    localparam int EEP_BLK_LSB = 8;
    localparam int EEP_CLK_PERIOD_NS = 50;
    localparam int EEP_LINK_PERIOD_NS = 400;
    localparam int EEP_LINK_QTR_CYC = EEP_LINK_PERIOD_NS / EEP_CLK_PERIOD_NS / 4;
    localparam int EEP_WRITE_TIME_US = 1000;
    localparam int EEP_WRITE_CYC = EEP_WRITE_TIME_US * 1000 / EEP_CLK_PERIOD_NS;
    localparam int EEP_FILT_LEN = 2;
    // Arbitrary value
    localparam logic [3:0] EEP_TYPE_CODE_DFLT = 4'h5;
    localparam logic [3:0] EEP_BITS_BYTE = 4'h8;
    localparam logic [3:0] EEP_BITS_SLOT = 4'h9;

    typedef enum logic [1:0] {
        EEP_OP_START = 2'h0,
        EEP_OP_STOP = 2'h1,
        EEP_OP_WRITE = 2'h2,
        EEP_OP_READ = 2'h3
    } eep_op_e;
endpackage

// [common/eep_bus_if.sv]
// Two-wire link between bus master and memory device
`timescale 1ns/1ps
interface eep_bus_if;
    logic scl;
    logic hostSdaOut;
    logic hostSdaOe_n;
    logic devSdaOut;
    logic devSdaOe_n;
    logic sda;

    // Open-drain wired AND with pull-up
    assign sda = ~((~hostSdaOe_n & ~hostSdaOut) | (~devSdaOe_n & ~devSdaOut));

    modport dev (input scl, input sda, output devSdaOut, output devSdaOe_n);
    modport host (output scl, output hostSdaOut, output hostSdaOe_n, input sda);
endinterface

// [hdl/eep_filter.sv]
// Synchroniser and spike filter for one bus input
`timescale 1ns/1ps
module eep_filter #(
    parameter int LEN = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Pin and filtered level
    input wire logic pinIn,
    output logic level
);
    localparam int CW = $clog2(LEN + 1);

    logic meta_reg;
    logic sync_reg;
    logic level_reg;
    logic level_next;
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    // A change must persist LEN samples; shorter spikes never reach the protocol logic
    always_comb begin
        level_next = level_reg;
        cnt_next = '0;
        if (sync_reg != level_reg) begin
            if (cnt_reg == CW'(LEN - 1)) begin
                level_next = sync_reg;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
            level_reg <= 1'b1;
            cnt_reg <= '0;
        end else begin
            meta_reg <= pinIn;
            sync_reg <= meta_reg;
            level_reg <= level_next;
            cnt_reg <= cnt_next;
        end
    end

    assign level = level_reg;
endmodule // eep_filter

// [hdl/eep_device.sv]
// Serial memory device end: reads, ack polling and write commit
`timescale 1ns/1ps
module eep_device import eep_pkg::*; #(
    parameter int WRITE_CYCLES = EEP_WRITE_CYC,
    parameter logic [3:0] TYPE_CODE = EEP_TYPE_CODE_DFLT,
    parameter int FILT_LEN = EEP_FILT_LEN
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Link
    eep_bus_if.dev bus,
    // User side
    input wire logic writeProtect,
    output logic writeBusy
);
    localparam int BW = $clog2(WRITE_CYCLES + 1);
    localparam int PAGES = 1 << EEP_PAGE_W;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_CTRL = 9'h002,
        ST_CTRL_ACK = 9'h004,
        ST_ADDR = 9'h008,
        ST_ADDR_ACK = 9'h010,
        ST_WDATA = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA = 9'h080,
        ST_RDATA_ACK = 9'h100
    } eep_dev_state_e;

    logic [EEP_DATA_W-1:0] mem [0:(1<<EEP_ADDR_W)-1];
    logic [EEP_DATA_W-1:0] pageBuf [0:PAGES-1];

    logic sclF;
    logic sdaF;
    logic wpF;
    logic sclPrev_reg;
    logic sdaPrev_reg;
    eep_dev_state_e state_reg, state_next;
    logic [3:0] bitCnt_reg, bitCnt_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] tx_reg, tx_next;
    logic [EEP_ADDR_W-1:0] ptr_reg, ptr_next;
    logic [EEP_ADDR_W-EEP_PAGE_W-1:0] base_reg, base_next;
    logic [PAGES-1:0] mask_reg, mask_next;
    logic [BW-1:0] busy_reg, busy_next;
    logic oe_n_reg, oe_n_next;
    logic rd_reg, rd_next;
    logic ackM_reg, ackM_next;
    logic commit;
    logic bufWr;
    logic sclRise;
    logic sclFall;
    logic startEv;
    logic stopEv;
    logic [7:0] memRd;

    eep_filter #(.LEN(FILT_LEN)) uSclFilt (.clk(clk), .arst_n(arst_n), .pinIn(bus.scl), .level(sclF));
    eep_filter #(.LEN(FILT_LEN)) uSdaFilt (.clk(clk), .arst_n(arst_n), .pinIn(bus.sda), .level(sdaF));
    eep_filter #(.LEN(FILT_LEN)) uWpFilt (.clk(clk), .arst_n(arst_n), .pinIn(writeProtect), .level(wpF));

    assign sclRise = sclF & ~sclPrev_reg;
    assign sclFall = ~sclF & sclPrev_reg;
    assign startEv = sclF & sclPrev_reg & sdaPrev_reg & ~sdaF;
    assign stopEv = sclF & sclPrev_reg & ~sdaPrev_reg & sdaF;
    assign memRd = mem[ptr_reg];

    always_comb begin
        state_next = state_reg;
        bitCnt_next = bitCnt_reg;
        sh_next = sh_reg;
        tx_next = tx_reg;
        ptr_next = ptr_reg;
        base_next = base_reg;
        mask_next = mask_reg;
        busy_next = (busy_reg != '0) ? busy_reg - 1'b1 : busy_reg;
        oe_n_next = oe_n_reg;
        rd_next = rd_reg;
        ackM_next = ackM_reg;
        commit = 1'b0;
        bufWr = 1'b0;
        if (stopEv) begin
            state_next = ST_IDLE;
            oe_n_next = 1'b1;
            mask_next = '0;
            if (mask_reg != '0 && !wpF) begin
                commit = 1'b1;
                busy_next = BW'(WRITE_CYCLES);
            end
        end else if (startEv) begin
            // Repeated start before Stop discards any gathered page data
            state_next = ST_CTRL;
            bitCnt_next = '0;
            oe_n_next = 1'b1;
            mask_next = '0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    oe_n_next = 1'b1;
                end
                ST_CTRL, ST_ADDR, ST_WDATA: begin
                    if (sclRise) begin
                        sh_next = {sh_reg[6:0], sdaF};
                        bitCnt_next = bitCnt_reg + 4'h1;
                    end else if (sclFall && bitCnt_reg == EEP_BITS_BYTE) begin
                        bitCnt_next = '0;
                        oe_n_next = 1'b0;
                        if (state_reg == ST_CTRL) begin
                            if (sh_reg[7:4] == TYPE_CODE && busy_reg == '0) begin
                                state_next = ST_CTRL_ACK;
                                rd_next = sh_reg[0];
                                ptr_next[EEP_ADDR_W-1:EEP_BLK_LSB] = sh_reg[3:1];
                            end else begin
                                state_next = ST_IDLE;
                                oe_n_next = 1'b1;
                            end
                        end else if (state_reg == ST_ADDR) begin
                            state_next = ST_ADDR_ACK;
                            ptr_next[EEP_BLK_LSB-1:0] = sh_reg;
                        end else begin
                            state_next = ST_WDATA_ACK;
                            bufWr = 1'b1;
                            mask_next[ptr_reg[EEP_PAGE_W-1:0]] = 1'b1;
                            base_next = ptr_reg[EEP_ADDR_W-1:EEP_PAGE_W];
                            ptr_next[EEP_PAGE_W-1:0] = ptr_reg[EEP_PAGE_W-1:0] + 1'b1;
                        end
                    end
                end
                ST_CTRL_ACK, ST_ADDR_ACK, ST_WDATA_ACK: begin
                    if (sclFall) begin
                        oe_n_next = 1'b1;
                        bitCnt_next = '0;
                        if (state_reg == ST_CTRL_ACK && rd_reg) begin
                            state_next = ST_RDATA;
                            tx_next = memRd;
                            oe_n_next = memRd[7];
                        end else if (state_reg == ST_CTRL_ACK) begin
                            state_next = ST_ADDR;
                        end else begin
                            state_next = ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclRise) begin
                        bitCnt_next = bitCnt_reg + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt_reg == EEP_BITS_BYTE) begin
                            state_next = ST_RDATA_ACK;
                            oe_n_next = 1'b1;
                            ptr_next = ptr_reg + 1'b1;
                        end else begin
                            tx_next = {tx_reg[6:0], 1'b0};
                            oe_n_next = tx_reg[6];
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    if (sclRise) begin
                        ackM_next = ~sdaF;
                    end else if (sclFall) begin
                        bitCnt_next = '0;
                        if (ackM_reg) begin
                            state_next = ST_RDATA;
                            tx_next = memRd;
                            oe_n_next = memRd[7];
                        end else begin
                            state_next = ST_IDLE;
                            oe_n_next = 1'b1;
                        end
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    oe_n_next = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
            state_reg <= ST_IDLE;
            bitCnt_reg <= '0;
            sh_reg <= '0;
            tx_reg <= '0;
            ptr_reg <= '0;
            base_reg <= '0;
            mask_reg <= '0;
            busy_reg <= '0;
            oe_n_reg <= 1'b1;
            rd_reg <= 1'b0;
            ackM_reg <= 1'b0;
        end else begin
            sclPrev_reg <= sclF;
            sdaPrev_reg <= sdaF;
            state_reg <= state_next;
            bitCnt_reg <= bitCnt_next;
            sh_reg <= sh_next;
            tx_reg <= tx_next;
            ptr_reg <= ptr_next;
            base_reg <= base_next;
            mask_reg <= mask_next;
            busy_reg <= busy_next;
            oe_n_reg <= oe_n_next;
            rd_reg <= rd_next;
            ackM_reg <= ackM_next;
        end
    end

    // Whole page lands in one cycle; the busy count stands in for the array timing
    always_ff @(posedge clk) begin
        if (bufWr) begin
            pageBuf[ptr_reg[EEP_PAGE_W-1:0]] <= sh_reg;
        end
        if (commit) begin
            for (int i = 0; i < PAGES; i++) begin
                if (mask_reg[i]) begin
                    mem[{base_reg, EEP_PAGE_W'(i)}] <= pageBuf[i];
                end
            end
        end
    end

    assign bus.devSdaOut = 1'b0;
    assign bus.devSdaOe_n = oe_n_reg;
    assign writeBusy = (busy_reg != '0);
endmodule // eep_device

// [hdl/eep_host.sv]
// Bus master end: byte-level Start, Stop, write and read primitives
`timescale 1ns/1ps
module eep_host import eep_pkg::*; #(
    parameter int QTR = EEP_LINK_QTR_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Link
    eep_bus_if.host bus,
    // Command
    input wire logic opValid,
    output logic opReady,
    input wire eep_op_e opCode,
    input wire logic [7:0] opData,
    input wire logic opAck,
    // Response
    output logic rspValid,
    output logic [7:0] rspData,
    output logic rspAckd
);
    localparam int DW = $clog2(QTR + 1);

    typedef enum logic [1:0] {
        H_IDLE = 2'b01,
        H_RUN = 2'b10
    } eep_host_state_e;

    eep_host_state_e state_reg, state_next;
    eep_op_e op_reg, op_next;
    logic [DW-1:0] div_reg, div_next;
    logic [1:0] q_reg, q_next;
    logic [3:0] bit_reg, bit_next;
    logic [8:0] sh_reg, sh_next;
    logic [8:0] rx_reg, rx_next;
    logic scl_reg, scl_next;
    logic oe_n_reg, oe_n_next;
    logic rspV_reg, rspV_next;
    logic [7:0] rspD_reg, rspD_next;
    logic rspA_reg, rspA_next;
    logic sdaMeta_reg;
    logic sdaSync_reg;
    logic tick;
    logic isBit;

    assign tick = (div_reg == DW'(QTR - 1));
    assign isBit = (op_reg == EEP_OP_WRITE) || (op_reg == EEP_OP_READ);
    assign opReady = (state_reg == H_IDLE);

    always_comb begin
        state_next = state_reg;
        op_next = op_reg;
        div_next = tick ? '0 : div_reg + 1'b1;
        q_next = q_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        rx_next = rx_reg;
        scl_next = scl_reg;
        oe_n_next = oe_n_reg;
        rspV_next = 1'b0;
        rspD_next = rspD_reg;
        rspA_next = rspA_reg;
        case (state_reg)
            H_IDLE: begin
                if (opValid) begin
                    state_next = H_RUN;
                    op_next = opCode;
                    q_next = '0;
                    bit_next = (opCode == EEP_OP_WRITE || opCode == EEP_OP_READ) ? EEP_BITS_SLOT : 4'h1;
                    // Read releases data bits and drives the ack slot low to ask for more
                    sh_next = (opCode == EEP_OP_WRITE) ? {opData, 1'b1} : {8'hFF, ~opAck};
                end
            end
            H_RUN: begin
                if (tick) begin
                    q_next = q_reg + 1'b1;
                    case (q_reg)
                        2'h0: begin
                            scl_next = 1'b0;
                            if (op_reg == EEP_OP_START) oe_n_next = 1'b1;
                            else if (op_reg == EEP_OP_STOP) oe_n_next = 1'b0;
                            else oe_n_next = sh_reg[8];
                        end
                        2'h1: begin
                            scl_next = 1'b1;
                        end
                        2'h2: begin
                            if (op_reg == EEP_OP_START) oe_n_next = 1'b0;
                            else if (op_reg == EEP_OP_STOP) oe_n_next = 1'b1;
                            else rx_next = {rx_reg[7:0], sdaSync_reg};
                        end
                        default: begin
                            if (op_reg != EEP_OP_STOP) scl_next = 1'b0;
                            sh_next = {sh_reg[7:0], 1'b1};
                            bit_next = bit_reg - 4'h1;
                            if (bit_reg == 4'h1) begin
                                state_next = H_IDLE;
                                rspV_next = 1'b1;
                                if (isBit) begin
                                    rspD_next = rx_reg[8:1];
                                    rspA_next = ~rx_reg[0];
                                end
                            end
                        end
                    endcase
                end
            end
            default: begin
                state_next = H_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= H_IDLE;
            op_reg <= EEP_OP_STOP;
            div_reg <= '0;
            q_reg <= '0;
            bit_reg <= '0;
            sh_reg <= '1;
            rx_reg <= '0;
            scl_reg <= 1'b1;
            oe_n_reg <= 1'b1;
            rspV_reg <= 1'b0;
            rspD_reg <= '0;
            rspA_reg <= 1'b0;
            sdaMeta_reg <= 1'b1;
            sdaSync_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            op_reg <= op_next;
            div_reg <= div_next;
            q_reg <= q_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            rx_reg <= rx_next;
            scl_reg <= scl_next;
            oe_n_reg <= oe_n_next;
            rspV_reg <= rspV_next;
            rspD_reg <= rspD_next;
            rspA_reg <= rspA_next;
            sdaMeta_reg <= bus.sda;
            sdaSync_reg <= sdaMeta_reg;
        end
    end

    assign bus.scl = scl_reg;
    assign bus.hostSdaOut = 1'b0;
    assign bus.hostSdaOe_n = oe_n_reg;
    assign rspValid = rspV_reg;
    assign rspData = rspD_reg;
    assign rspAckd = rspA_reg;
endmodule // eep_host

// [tb/eep_link_assertions.sv]
// Concurrent checks on the two-wire link between host and device
`timescale 1ns/1ps
module eep_link_assertions #(
    parameter int WRITE_CYCLES = 200
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Link wires
    input wire logic scl,
    input wire logic hostSdaOut,
    input wire logic hostSdaOe_n,
    input wire logic devSdaOut,
    input wire logic devSdaOe_n,
    input wire logic sda,
    // Device status
    input wire logic writeBusy
);
    logic [7:0] devLowCnt_reg, devLowCnt_next;
    logic [31:0] busyCnt_reg, busyCnt_next;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Saturation not needed: the bound below fires long before wrap
    always_comb begin
        devLowCnt_next = devSdaOe_n ? 8'h00 : devLowCnt_reg + 8'h01;
        busyCnt_next = writeBusy ? busyCnt_reg + 32'h1 : 32'h0;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            devLowCnt_reg <= 8'h00;
            busyCnt_reg <= 32'h0;
        end else begin
            devLowCnt_reg <= devLowCnt_next;
            busyCnt_reg <= busyCnt_next;
        end
    end

    quiet_after_reset_a: assert property ($rose(arst_n) |-> (devSdaOe_n && scl) [*2])
        else $error("link not idle after reset");
    busy_no_ack_a: assert property (writeBusy |-> devSdaOe_n)
        else $error("device drives data while write busy");
    busy_after_stop_a: assert property ($rose(writeBusy) |-> scl && sda && $past(scl, 2))
        else $error("write cycle started without stop");
    busy_length_a: assert property ($fell(writeBusy) |->
        busyCnt_reg >= WRITE_CYCLES - 1 && busyCnt_reg <= WRITE_CYCLES + 1)
        else $error("write cycle length wrong");
    dev_drive_bound_a: assert property (devLowCnt_reg < 8'h5A)
        else $error("device holds data low too long");
    start_hold_a: assert property ($fell(sda) && scl |-> scl [*2])
        else $error("clock fell during start");
    scl_high_a: assert property ($rose(scl) |-> scl [*4])
        else $error("clock high phase too short");
    scl_low_a: assert property ($fell(scl) |-> !scl [*4])
        else $error("clock low phase too short");
endmodule // eep_link_assertions

// [tb/serial_eeprom_read_and_ack_poll_test.sv]
// Self-checking bench: host end driving device end over the link
`timescale 1ns/1ps
module serial_eeprom_read_and_ack_poll_test;
    import eep_pkg::*;
    // Short write cycle keeps polling loops brief
    localparam int WCYC = 200;
    // Device answers about five clocks after a clock fall, so the low phase must be longer than that
    localparam int LINK_QTR = 4;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic opValid = 1'b0;
    eep_op_e opCode = EEP_OP_START;
    logic [7:0] opData = 8'h00;
    logic opAck = 1'b0;
    logic writeProtect = 1'b0;
    logic opReady, rspValid, rspAckd, writeBusy;
    logic [7:0] rspData, rd;
    logic ak;
    int n_fail = 0;
    int n_checks = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    eep_bus_if busIf();
    eep_host #(.QTR(LINK_QTR)) eep_host_inst(.clk(clk), .arst_n(arst_n), .bus(busIf), .opValid(opValid),
        .opReady(opReady),
        .opCode(opCode), .opData(opData), .opAck(opAck), .rspValid(rspValid), .rspData(rspData),
        .rspAckd(rspAckd));
    eep_device #(.WRITE_CYCLES(WCYC)) eep_device_inst(.clk(clk), .arst_n(arst_n), .bus(busIf),
        .writeProtect(writeProtect), .writeBusy(writeBusy));
    eep_link_assertions #(.WRITE_CYCLES(WCYC)) eep_link_assertions_inst(.clk(clk), .arst_n(arst_n),
        .scl(busIf.scl), .hostSdaOut(busIf.hostSdaOut), .hostSdaOe_n(busIf.hostSdaOe_n),
        .devSdaOut(busIf.devSdaOut), .devSdaOe_n(busIf.devSdaOe_n), .sda(busIf.sda), .writeBusy(writeBusy));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One host command, held until taken, then wait for its response
    task automatic op(input eep_op_e c, input logic [7:0] d, input logic a);
        int w;
        @(posedge clk);
        opValid <= 1'b1;
        opCode <= c;
        opData <= d;
        opAck <= a;
        @(negedge clk);
        while (opReady !== 1'b1) @(negedge clk);
        @(posedge clk);
        opValid <= 1'b0;
        w = 0;
        @(negedge clk);
        while (rspValid !== 1'b1 && w < 400) begin
            @(negedge clk);
            w++;
        end
        if (w >= 400) n_fail++;
        rd = rspData;
        ak = rspAckd;
    endtask

    function automatic logic [7:0] ctrl(input logic [2:0] blk, input logic rw);
        return {EEP_TYPE_CODE_DFLT, blk, rw};
    endfunction

    task automatic bstart(); op(EEP_OP_START, 8'h00, 1'b0); endtask
    task automatic bstop(); op(EEP_OP_STOP, 8'h00, 1'b0); endtask
    task automatic wr(input logic [7:0] d, input logic expAck);
        op(EEP_OP_WRITE, d, 1'b0);
        check({7'h0, ak}, {7'h0, expAck});
    endtask
    task automatic rdb(input logic a, input logic [7:0] exp);
        op(EEP_OP_READ, 8'h00, a);
        check(rd, exp);
    endtask

    // Page write, then poll with write control bytes until acknowledged
    task automatic wr_page(input logic [2:0] blk, input logic [7:0] addr, input int n, input logic [23:0] d);
        int polls;
        bstart();
        wr(ctrl(blk, 1'b0), 1'b1);
        wr(addr, 1'b1);
        for (int i = 0; i < n; i++) wr(d[23-8*i -: 8], 1'b1);
        bstop();
        bstart();
        wr(ctrl(blk, 1'b0), 1'b0);
        polls = 0;
        while (ak !== 1'b1 && polls < 30) begin
            bstop();
            bstart();
            op(EEP_OP_WRITE, ctrl(blk, 1'b0), 1'b0);
            polls++;
        end
        check({7'h0, ak}, 8'h01);
        bstop();
    endtask

    task automatic rand_read(input logic [2:0] blk, input logic [7:0] addr);
        bstart();
        wr(ctrl(blk, 1'b0), 1'b1);
        wr(addr, 1'b1);
        bstart();
        wr(ctrl(blk, 1'b1), 1'b1);
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        bstart();
        wr({EEP_TYPE_CODE_DFLT ^ 4'h3, 3'h0, 1'b1}, 1'b0);
        rdb(1'b0, 8'hFF);
        bstop();
        $display("Test foreign code done");
        wr_page(3'h0, 8'h00, 2, 24'h112200);
        wr_page(3'h0, 8'hFF, 1, 24'h330000);
        wr_page(3'h1, 8'h00, 1, 24'h440000);
        wr_page(3'h7, 8'hFE, 3, 24'hA0A1A2);
        $display("Test writes with polling done");
        rand_read(3'h7, 8'hFE);
        rdb(1'b1, 8'hA0);
        rdb(1'b1, 8'hA1);
        rdb(1'b0, 8'h11);
        // The device reacts a few clocks after the clock fall; look once it would have driven
        repeat (8) @(negedge clk);
        check({7'h0, busIf.devSdaOe_n}, 8'h01);
        bstop();
        repeat (8) @(negedge clk);
        check({7'h0, writeBusy}, 8'h00);
        bstart();
        wr(ctrl(3'h0, 1'b1), 1'b1);
        rdb(1'b0, 8'h22);
        repeat (8) @(negedge clk);
        check({7'h0, busIf.devSdaOe_n}, 8'h01);
        bstop();
        rand_read(3'h7, 8'hF0);
        rdb(1'b0, 8'hA2);
        bstop();
        rand_read(3'h0, 8'hFF);
        rdb(1'b1, 8'h33);
        rdb(1'b0, 8'h44);
        bstop();
        // Data byte gathered, then a repeated Start: nothing may be stored
        bstart();
        wr(ctrl(3'h1, 1'b0), 1'b1);
        wr(8'h00, 1'b1);
        wr(8'h99, 1'b1);
        rand_read(3'h1, 8'h00);
        rdb(1'b0, 8'h44);
        bstop();
        repeat (8) @(negedge clk);
        check({7'h0, writeBusy}, 8'h00);
        $display("Test reads done");
        @(posedge clk);
        writeProtect <= 1'b1;
        bstart();
        wr(ctrl(3'h0, 1'b0), 1'b1);
        wr(8'h00, 1'b1);
        wr(8'h55, 1'b1);
        bstop();
        repeat (8) @(negedge clk);
        check({7'h0, writeBusy}, 8'h00);
        rand_read(3'h0, 8'h00);
        rdb(1'b0, 8'h11);
        bstop();
        $display("Test write protect done");
        final_report();
    end
endmodule // serial_eeprom_read_and_ack_poll_test
